//--- logic/ethirq_pkg.sv
// Constants for the Ethernet interrupt flag and enable logic.
// Assumes a single system clock and register strobes from the CPU side.
package ethirq_pkg;

    // ========================================
    // Register widths
    localparam int ETHIRQ_REG_W = 8;
    localparam int ETHIRQ_PHY_W = 16;
    localparam int ETHIRQ_CNT_W = 8;
    localparam int ETHIRQ_PTR_W = 13;

    // ========================================
    // Module enable and flag bit positions
    localparam int BIT_PKT = 6;
    localparam int BIT_DMA = 5;
    localparam int BIT_LINK = 4;
    localparam int BIT_TX = 3;
    localparam int BIT_TXER = 1;
    localparam int BIT_RXER = 0;

    // Writable enable bits and software-clearable flag bits
    localparam logic [7:0] ENABLE_MASK = 8'h7B;
    localparam logic [7:0] CLEARABLE_MASK = 8'h2B;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ========================================
    // PHY enable and flag bit positions
    localparam int PHY_BIT_LINK = 4;
    localparam int PHY_BIT_GLOBAL = 1;
    localparam int PHY_BIT_GFLAG = 2;
    localparam logic [15:0] PHY_RESET = 16'h0000;

    // ========================================
    // Status register bit positions
    localparam int STAT_BIT_BUFFER_ERROR_STATUS = 6;
    localparam int STAT_BIT_ABORT = 1;

    // ========================================
    // Abort and receive error limits
    localparam logic [4:0] MAX_COLLISIONS = 5'h0F;
    localparam logic [10:0] LATE_COLLISION_BYTES = 11'h040;
    localparam logic [7:0] PACKET_COUNT_MAX = 8'hFF;
    localparam logic [7:0] PACKET_COUNT_ZERO = 8'h00;

endpackage

//--- logic/ethirq_top.sv
// Ethernet interrupt flag, enable and abort handling logic.
// Assumes all inputs are synchronous to clock; event inputs are one-cycle
// pulses, counters and control levels come from the surrounding MAC.
`timescale 1ns/1ps

// Function
// - Module flags set regardless of enables, except link
// - Master flag from enabled flag and global enable
// - Enable register bits 6,5,4,3,1,0 writable
// - Flags share positions; some software clearable
// - Transmit abort sets transmit error flag
// - PHY enable: bits 4 and 1 writable only
// - PHY link flag set on change, read clears
// - PHY global flag set on enabled event, read clears
// - Three receive error causes detected
// - Receive error discards packet, sticky flag
// - Bandwidth receive error sets buffer error status
// - Abort: collisions, late collision, deferral limit
// - Abort: oversized frame or buffer underrun
// - Transmit error flag sticky until cleared
// - Abort clears request, sets abort status, vector
// - Aborted packet never retried automatically
// - Full duplex: only oversize and underrun abort
// - Transmit error also sets transmit flag
// - Link flag mirrors PHY global flag when enabled
// - Packet flag set while counter non-zero
// - DMA flag set when DMA busy falls
module ethirq_top
    import ethirq_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // Register strobes from the CPU side
    input wire logic enable_wr,
    input wire logic [7:0] enable_wdata,
    input wire logic flags_wr,
    input wire logic [7:0] flags_wdata,
    input wire logic phy_enable_wr,
    input wire logic [15:0] phy_enable_wdata,
    input wire logic phy_flags_rd,
    input wire logic status_wr,
    input wire logic [7:0] status_wdata,
    input wire logic global_ethernet_irq_enable,
    // Receive side
    input wire logic [7:0] received_packet_counter,
    input wire logic rx_no_space,
    input wire logic rx_packet_commit,
    input wire logic rx_bandwidth_error,
    // DMA and transmit side
    input wire logic dma_start_busy,
    input wire logic transmit_request,
    input wire logic [12:0] transmit_end_pointer,
    input wire logic full_duplex,
    input wire logic tx_collision,
    input wire logic [4:0] tx_collision_count,
    input wire logic [10:0] tx_bytes_sent,
    input wire logic deferral_limit_reached,
    input wire logic infinite_deferral_enable,
    input wire logic tx_frame_start,
    input wire logic [15:0] tx_frame_length,
    input wire logic [15:0] max_frame_length,
    input wire logic huge_frame_enable,
    input wire logic per_packet_override,
    input wire logic per_packet_huge_enable,
    input wire logic tx_underrun,
    // PHY side
    input wire logic phy_link_up,
    // Register contents and results
    output logic [7:0] ethernet_irq_enable,
    output logic [7:0] ethernet_irq_flags,
    output logic [15:0] phy_irq_enable,
    output logic [15:0] phy_irq_flags,
    output logic master_ethernet_irq_flag,
    output logic buffer_error_status,
    output logic transmit_abort_status,
    output logic transmit_request_clear,
    output logic transmit_status_write,
    output logic [12:0] transmit_status_address,
    output logic rx_discard
);

    // ========================================
    // Edge detection state
    logic dma_busy_q;
    logic tx_req_q;
    logic link_up_q;
    logic link_seen;

    // ========================================
    // Event decode
    logic rx_err_space;
    logic rx_err_count;
    logic rx_err_bw;
    logic rx_error_event;
    logic abort_retry;
    logic abort_late;
    logic abort_infinite_deferral_enable;
    logic abort_size;
    logic abort_under;
    logic tx_abort_event;
    logic dma_done_event;
    logic tx_done_event;
    logic link_change_event;
    logic phy_en_link;
    logic phy_en_global;
    logic [7:0] flag_set;
    logic [7:0] flag_clear;
    logic [7:0] next_flags;
    logic [7:0] next_enable;
    logic [15:0] next_phy_flags;

    // Receive error causes
    assign rx_err_space = rx_no_space;
    assign rx_err_count = rx_packet_commit &&
        (received_packet_counter == PACKET_COUNT_MAX);
    assign rx_err_bw = rx_bandwidth_error;
    assign rx_error_event = rx_err_space || rx_err_count || rx_err_bw;

    // Transmit abort causes; shared-medium causes masked in full duplex
    assign abort_retry = tx_collision &&
        (tx_collision_count > MAX_COLLISIONS) && !full_duplex;
    assign abort_late = tx_collision &&
        (tx_bytes_sent > LATE_COLLISION_BYTES) && !full_duplex;
    assign abort_infinite_deferral_enable = deferral_limit_reached &&
        !infinite_deferral_enable && !full_duplex;
    assign abort_size = tx_frame_start &&
        (tx_frame_length > max_frame_length) && !huge_frame_enable &&
        !(per_packet_override && per_packet_huge_enable);
    assign abort_under = tx_underrun;
    assign tx_abort_event = transmit_request && (abort_retry || abort_late ||
        abort_infinite_deferral_enable || abort_size || abort_under);

    // Falling edges of the DMA busy and transmit request levels; any change of the PHY link level
    assign dma_done_event = dma_busy_q && !dma_start_busy;
    assign tx_done_event = tx_req_q && !transmit_request;
    assign link_change_event = link_seen && (phy_link_up != link_up_q);

    // Next enable image, so the master flag sees a write in the same edge
    always_comb begin
        next_enable = ethernet_irq_enable;
        if (enable_wr) begin
            next_enable = enable_wdata & ENABLE_MASK;
        end
    end

    assign phy_en_link = phy_irq_enable[PHY_BIT_LINK];
    assign phy_en_global = phy_irq_enable[PHY_BIT_GLOBAL];

    // Set terms per flag; transmit error also marks transmit done
    always_comb begin
        flag_set = REG_RESET;
        flag_set[BIT_DMA] = dma_done_event;
        flag_set[BIT_TX] = tx_done_event || tx_abort_event;
        flag_set[BIT_TXER] = tx_abort_event;
        flag_set[BIT_RXER] = rx_error_event;
    end

    // Software write of zero clears a clearable flag
    always_comb begin
        flag_clear = REG_RESET;
        if (flags_wr) begin
            flag_clear = ~flags_wdata & CLEARABLE_MASK;
        end
    end

    // Next flag image; sticky flags keep value, set wins over clear
    always_comb begin
        next_flags = ((ethernet_irq_flags & ~flag_clear) | flag_set)
            & CLEARABLE_MASK;
        next_flags[BIT_PKT] =
            (received_packet_counter != PACKET_COUNT_ZERO);
        next_flags[BIT_LINK] = phy_en_link && phy_en_global &&
            next_phy_flags[PHY_BIT_GFLAG];
    end

    // Next PHY flag image; a read clears, a new change wins
    always_comb begin
        next_phy_flags = phy_irq_flags;
        if (phy_flags_rd) begin
            next_phy_flags = PHY_RESET;
        end
        if (link_change_event) begin
            next_phy_flags[PHY_BIT_LINK] = 1'b1;
        end
        if (link_change_event && phy_en_link && phy_en_global) begin
            next_phy_flags[PHY_BIT_GFLAG] = 1'b1;
        end
    end

    // ========================================
    // Edge detect registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dma_busy_q <= 1'b0;
            tx_req_q <= 1'b0;
            link_up_q <= 1'b0;
            link_seen <= 1'b0;
        end else if (clk_en) begin
            dma_busy_q <= dma_start_busy;
            tx_req_q <= transmit_request;
            link_up_q <= phy_link_up;
            link_seen <= 1'b1; // First sample only primes the compare
        end
    end

    // ========================================
    // Module enable register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ethernet_irq_enable <= REG_RESET;
        end else if (clk_en) begin
            ethernet_irq_enable <= next_enable;
        end
    end

    // ========================================
    // Module flag register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ethernet_irq_flags <= REG_RESET;
        end else if (clk_en) begin
            ethernet_irq_flags <= next_flags;
        end
    end

    // ========================================
    // PHY enable register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phy_irq_enable <= PHY_RESET;
        end else if (clk_en && phy_enable_wr) begin
            phy_irq_enable <= PHY_RESET;
            phy_irq_enable[PHY_BIT_LINK] <=
                phy_enable_wdata[PHY_BIT_LINK];
            phy_irq_enable[PHY_BIT_GLOBAL] <=
                phy_enable_wdata[PHY_BIT_GLOBAL];
        end
    end

    // ========================================
    // PHY flag register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phy_irq_flags <= PHY_RESET;
        end else if (clk_en) begin
            phy_irq_flags <= next_phy_flags;
        end
    end

    // ========================================
    // Master interrupt, from the registered next flag image
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            master_ethernet_irq_flag <= 1'b0;
        end else if (clk_en) begin
            master_ethernet_irq_flag <= global_ethernet_irq_enable &&
                (|(next_flags & next_enable));
        end
    end

    // ========================================
    // Status bits; hardware set wins over a software clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            buffer_error_status <= 1'b0;
            transmit_abort_status <= 1'b0;
        end else if (clk_en) begin
            if (rx_err_bw || (transmit_request && abort_under)) begin
                buffer_error_status <= 1'b1;
            end else if (status_wr && !status_wdata[STAT_BIT_BUFFER_ERROR_STATUS]) begin
                buffer_error_status <= 1'b0;
            end
            if (tx_abort_event) begin
                transmit_abort_status <= 1'b1;
            end else if (status_wr && !status_wdata[STAT_BIT_ABORT]) begin
                transmit_abort_status <= 1'b0;
            end
        end
    end

    // ========================================
    // Abort actions: end request and write status vector, no retry
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            transmit_request_clear <= 1'b0;
            transmit_status_write <= 1'b0;
            transmit_status_address <= '0;
        end else if (clk_en) begin
            transmit_request_clear <= tx_abort_event;
            transmit_status_write <= tx_abort_event;
            if (tx_abort_event) begin
                transmit_status_address <=
                    transmit_end_pointer + 13'h0001;
            end
        end
    end

    // ========================================
    // Receive discard pulse
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_discard <= 1'b0;
        end else if (clk_en) begin
            rx_discard <= rx_error_event;
        end
    end

endmodule

//--- tb/ethirq_sva.sv
// Checker for the Ethernet interrupt flag logic, bound to its top.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
module ethirq_sva (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic global_ethernet_irq_enable,
    input wire logic [7:0] received_packet_counter,
    input wire logic dma_start_busy,
    input wire logic transmit_request,
    input wire logic tx_underrun,
    input wire logic flags_wr,
    input wire logic [7:0] flags_wdata,
    input wire logic [7:0] ethernet_irq_enable,
    input wire logic [7:0] ethernet_irq_flags,
    input wire logic [15:0] phy_irq_enable,
    input wire logic master_ethernet_irq_flag,
    input wire logic transmit_abort_status,
    input wire logic transmit_request_clear
);
    // ========================================
    // Flag, enable and abort properties
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_enable_reserved: assert property (
        (ethernet_irq_enable & 8'h84) == 8'h00) else $error("enable rsv");
    a_phy_reserved: assert property (
        (phy_irq_enable & 16'hFFED) == 16'h0000) else $error("phy rsv");
    a_master_merge: assert property ($past(clk_en) && $past(rst_n) |->
        master_ethernet_irq_flag == ($past(global_ethernet_irq_enable)
        && |(ethernet_irq_flags & ethernet_irq_enable))) else $error("master");
    a_pkt_follows: assert property ($past(clk_en) && $past(rst_n) |->
        ethernet_irq_flags[6] == ($past(received_packet_counter) != 8'h00))
        else $error("packet flag");
    a_txer_pairs: assert property ($rose(ethernet_irq_flags[1]) |->
        ethernet_irq_flags[3]) else $error("tx flag pair");
    a_txer_sticky: assert property (ethernet_irq_flags[1] &&
        !(clk_en && flags_wr && !flags_wdata[1]) |=> ethernet_irq_flags[1])
        else $error("tx error lost");
    a_underrun_abort: assert property (
        clk_en && transmit_request && tx_underrun |=> transmit_request_clear
        && transmit_abort_status && ethernet_irq_flags[1]) else $error("abort");
    a_dma_fall: assert property (
        clk_en && $past(clk_en) && $fell(dma_start_busy) |=>
        ethernet_irq_flags[5]) else $error("dma flag");
    // Main scenarios reached
    c_master: cover property (master_ethernet_irq_flag);
    c_abort: cover property (transmit_request_clear);
    c_dma: cover property ($fell(dma_start_busy));
endmodule

bind ethirq_top ethirq_sva u_sva (.clock, .rst_n, .clk_en,
    .global_ethernet_irq_enable, .received_packet_counter, .dma_start_busy,
    .transmit_request, .tx_underrun, .flags_wr, .flags_wdata,
    .ethernet_irq_enable, .ethernet_irq_flags, .phy_irq_enable,
    .master_ethernet_irq_flag, .transmit_abort_status, .transmit_request_clear);

//--- tb/ethirq_cpu.sv
// CPU-side register access model for the Ethernet interrupt logic.
// Assumes strobe index 0..4: enable, flags, PHY enable, PHY read, status.
`timescale 1ns/1ps
module ethirq_cpu (
    input wire logic clock,
    output logic [4:0] stb,
    output logic [15:0] wd
);
    // Bus idle at time zero
    initial begin
        stb = 5'h00;
        wd = 16'h0000;
    end
    // One access: strobe held for exactly one rising edge
    task automatic access(input int k, input logic [15:0] d);
        @(negedge clock);
        stb = 5'h01 << k;
        wd = d;
        @(negedge clock);
        stb = 5'h00;
        wd = ~d; // Released data shows no stale value
    endtask
endmodule

//--- tb/test_ethernet_interrupt_logic.sv
// Self-checking bench for the Ethernet interrupt flag logic.
// Assumes the CPU model drives register strobes; events come from here.
`timescale 1ns/1ps
module test_ethernet_interrupt_logic;
    // ========================================
    // Design inputs, outputs and bench model
    logic clock = 1'b0, rst_n = 1'b0, clk_en = 1'b1, phy_link_up = 1'b0;
    logic global_ethernet_irq_enable = 1'b0, dma_start_busy = 1'b0;
    logic transmit_request = 1'b0, full_duplex = 1'b0;
    logic infinite_deferral_enable = 1'b0, huge_frame_enable = 1'b0;
    logic per_packet_override = 1'b0, per_packet_huge_enable = 1'b0;
    logic [7:0] received_packet_counter = 8'h00;
    logic [6:0] ev = 7'h00;
    logic [12:0] transmit_end_pointer = 13'h0000, transmit_status_address;
    logic [4:0] tx_collision_count = 5'h00, stb;
    logic [10:0] tx_bytes_sent = 11'h000;
    logic [15:0] tx_frame_length = 16'h0000, max_frame_length = 16'h05EE, wd;
    logic [7:0] ethernet_irq_enable, ethernet_irq_flags;
    logic [15:0] phy_irq_enable, phy_irq_flags;
    logic master_ethernet_irq_flag, buffer_error_status, rx_discard;
    logic transmit_abort_status, transmit_request_clear, transmit_status_write;
    logic [7:0] en = 8'h00, mf = 8'h00;
    logic [15:0] pe = 16'h0000, pf = 16'h0000;
    logic [1:0] ms = 2'b00;
    logic [31:0] rs = 32'h1F, v;
    int fails = 0, checks_done = 0;

    ethirq_cpu cpu (.clock, .stb, .wd);
    ethirq_top DUT (.clock, .rst_n, .clk_en, .enable_wr(stb[0]),
        .enable_wdata(wd[7:0]), .flags_wr(stb[1]), .flags_wdata(wd[7:0]),
        .phy_enable_wr(stb[2]), .phy_enable_wdata(wd), .phy_flags_rd(stb[3]),
        .status_wr(stb[4]), .status_wdata(wd[7:0]), .global_ethernet_irq_enable,
        .received_packet_counter, .rx_no_space(ev[0]), .rx_packet_commit(ev[1]),
        .rx_bandwidth_error(ev[2]), .dma_start_busy, .transmit_request,
        .transmit_end_pointer, .full_duplex, .tx_collision(ev[3]),
        .tx_collision_count, .tx_bytes_sent, .deferral_limit_reached(ev[4]),
        .infinite_deferral_enable, .tx_frame_start(ev[5]), .tx_frame_length,
        .max_frame_length, .huge_frame_enable, .per_packet_override,
        .per_packet_huge_enable, .tx_underrun(ev[6]), .phy_link_up,
        .ethernet_irq_enable, .ethernet_irq_flags, .phy_irq_enable,
        .phy_irq_flags, .master_ethernet_irq_flag, .buffer_error_status,
        .transmit_abort_status, .transmit_request_clear, .transmit_status_write,
        .transmit_status_address, .rx_discard);

    // 200 MHz clock
    always #2.5 clock = ~clock;

    // ========================================
    // Helpers
    function automatic logic [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Compare every register image against the model
    task automatic cmp();
        logic [7:0] f;
        logic m;
        f = mf & 8'h2B;
        f[6] = received_packet_counter != 8'h00;
        f[4] = pf[2] & pe[4] & pe[1];
        m = |(f & en) && global_ethernet_irq_enable;
        chk(16'(ethernet_irq_flags), 16'(f));
        chk(16'(ethernet_irq_enable), 16'(en));
        chk(phy_irq_enable, pe);
        chk(phy_irq_flags, pf);
        chk(16'(master_ethernet_irq_flag), 16'(m));
        chk(16'({buffer_error_status, transmit_abort_status}), 16'(ms));
        chk(16'({transmit_request_clear, rx_discard}), 16'h0000);
    endtask
    // Receive event b with the counter at n
    task automatic rxc(input int b, input logic [7:0] n, input logic er);
        received_packet_counter = n;
        tick(1);
        ev[b] = 1'b1;
        tick(1);
        ev = 7'h00;
        chk(16'(rx_discard), 16'(er));
        tick(1);
        if (er) mf[0] = 1'b1;
        if (b == 2) ms[1] = 1'b1;
        cmp();
    endtask
    // Transmit with event b, then drop the request
    task automatic txc(input int b, input logic [4:0] c, input logic [10:0] by,
        input logic fd, input logic df, input logic [15:0] ln, input logic ab);
        transmit_end_pointer = 13'(xs());
        tx_collision_count = c;
        tx_bytes_sent = by;
        full_duplex = fd;
        infinite_deferral_enable = df;
        tx_frame_length = ln;
        transmit_request = 1'b1;
        tick(1);
        ev[b] = 1'b1;
        tick(1);
        ev = 7'h00;
        chk(16'({transmit_request_clear, transmit_status_write}), 16'({ab, ab}));
        if (ab) chk(16'(transmit_status_address),
            16'(13'(transmit_end_pointer + 13'h0001)));
        transmit_request = 1'b0;
        tick(2);
        mf[3] = 1'b1;
        if (ab) mf[1] = 1'b1;
        if (ab) ms[0] = 1'b1;
        if (ab && b == 6) ms[1] = 1'b1;
        cmp();
        cpu.access(1, 16'h0000);
        cpu.access(4, 16'h0000);
        mf = 8'h00;
        ms = 2'b00;
        cmp();
    endtask
    task automatic results();
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog: the sequence needs well under 1000 cycles
    initial begin
        #10000;
        fails++;
        results();
    end

    // ========================================
    // Main sequence
    initial begin
        repeat (3) @(posedge clock);
        @(negedge clock);
        rst_n = 1'b1;
        tick(1);
        cmp();
        clk_en = 1'b0;
        cpu.access(0, 16'h00FF);
        clk_en = 1'b1;
        cmp();
        repeat (4) begin
            v = xs();
            cpu.access(0, v[15:0]);
            cpu.access(2, v[15:0]);
            en = v[7:0] & 8'h7B;
            pe = v[15:0] & 16'h0012;
            cmp();
        end
        rxc(0, 8'h03, 1'b1);
        rxc(1, 8'hFE, 1'b0);
        rxc(1, 8'hFF, 1'b1);
        rxc(2, 8'h00, 1'b1);
        cpu.access(0, 16'h007B);
        en = 8'h7B;
        global_ethernet_irq_enable = 1'b1;
        txc(3, 5'h10, 11'h000, 1'b0, 1'b0, 16'h0000, 1'b1);
        txc(3, 5'h0F, 11'h040, 1'b0, 1'b0, 16'h0000, 1'b0);
        txc(3, 5'h01, 11'h041, 1'b0, 1'b0, 16'h0000, 1'b1);
        txc(3, 5'h10, 11'h041, 1'b1, 1'b0, 16'h0000, 1'b0);
        txc(4, 5'h00, 11'h000, 1'b0, 1'b0, 16'h0000, 1'b1);
        txc(4, 5'h00, 11'h000, 1'b0, 1'b1, 16'h0000, 1'b0);
        txc(5, 5'h00, 11'h000, 1'b0, 1'b0, 16'h05EF, 1'b1);
        txc(5, 5'h00, 11'h000, 1'b0, 1'b0, 16'h05EE, 1'b0);
        txc(5, 5'h00, 11'h000, 1'b1, 1'b0, 16'h05EF, 1'b1);
        txc(6, 5'h00, 11'h000, 1'b1, 1'b0, 16'h0000, 1'b1);
        // DMA completion lands on the same edge as a flag clear
        dma_start_busy = 1'b1;
        fork
            cpu.access(1, 16'h0000);
            begin
                tick(1);
                dma_start_busy = 1'b0;
            end
        join
        mf = 8'h20;
        cmp();
        cpu.access(2, 16'h0012);
        pe = 16'h0012;
        cpu.access(3, 16'h0000);
        phy_link_up = 1'b1;
        tick(3);
        pf = 16'h0014;
        cmp();
        cpu.access(3, 16'h0000);
        tick(1);
        pf = 16'h0000;
        cmp();
        cpu.access(2, 16'h0000);
        pe = 16'h0000;
        phy_link_up = 1'b0;
        tick(3);
        pf = 16'h0010;
        cmp();
        results();
    end
endmodule
